/* shared/bst_regs.vh */
// Purpose: constants for the boundary-scan test port
// Assumes: 4-bit instruction field, 32-bit identification word
// Notes:   included by hw/bst_tap.v and by the checker and bench, not the controller model
`ifndef BST_REGS_VH
`define BST_REGS_VH

// Instruction field
`define BST_IR_W          4
`define BST_IR_CAPTURE    4'h1
`define BST_OP_EXTEST     4'h0
`define BST_OP_SAMPLE     4'h1
`define BST_OP_IDCODE     4'h2
`define BST_OP_HIGHZ      4'h3
`define BST_OP_CLAMP      4'h8
`define BST_OP_BYPASS     4'hF
`define BST_OP_RESET      `BST_OP_IDCODE

// Identification word layout
`define BST_ID_W          32
`define BST_ID_REV_MSB    31
`define BST_ID_REV_LSB    28
`define BST_ID_PART_MSB   27
`define BST_ID_PART_LSB   12
`define BST_ID_MFR_MSB    11
`define BST_ID_MFR_LSB    1
`define BST_ID_MARK_BIT   0
`define BST_ID_MARK       1'h1

// Data register select codes
`define BST_SEL_BYPASS    2'h0
`define BST_SEL_CHAIN     2'h1
`define BST_SEL_IDENT     2'h2

// Serial output buffer
`define BST_BUF_DEPTH     2'h2

`endif

/* hw/bst_tap.v */
// Purpose: boundary-scan test port with state machine, instruction
//          decode, bypass stage, boundary chain and identification word
// Assumes: test clock much slower than clk_in; all test pins sampled
//          through two flip-flops on clk_in
// Notes:   pin outputs are registered, so they follow one cycle late
`timescale 1ns/100ps
`include "bst_regs.vh"

// Behaviour
// - State moves on test-clock rise, by mode-select
// - Five mode-select highs always reach reset state
// - Power-up reset places state in reset
// - Reset state disables all test logic
// - Idle state activates logic only for test instructions
// - Capture-IR loads fixed pattern ending 01
// - Shift-IR shifts instruction; output changes on fall
// - Pause-IR holds instruction shift stage
// - Update-IR latches instruction on falling edge
// - Capture-DR loads register chosen by instruction
// - Data path states mirror instruction path
// - Instruction is a four bit field
// - Decode pin test, sample, identify, bypass codes
// - Decode high impedance and clamp codes
// - Three data registers share serial in, out
// - Bypass stage cleared in Capture-DR when selected
// - Bypass shifting leaves function unaffected
// - Chain: one cell per input, bidirectional pin
// - Chain drives outputs, captures core and pins
// - Identification word 32 bits, read only
// - Identification fields: revision, part, maker, one
// - Pin test drives chain outputs, captures inputs
// - Clamp and high impedance route bypass stage
// - Identification selected after reset
module bst_tap #(
    parameter NUM_IN   = 4,                     // Functional input pins
    parameter NUM_IO   = 4,                     // Bidirectional pins
    parameter [3:0]  ID_REVISION = 4'h1,        // Arbitrary value
    parameter [15:0] ID_PART     = 16'h5A5A,    // Arbitrary value
    parameter [10:0] ID_MAKER    = 11'h2A5      // Arbitrary value
) (
    input  wire              clk_in,            // System clock
    input  wire              rst_in,            // Async power-up reset
    input  wire              tck_in,            // Test clock pin
    input  wire              tms_in,            // Mode select pin
    input  wire              tdi_in,            // Serial data in pin
    output reg               tdo_out,           // Serial data out
    output reg               tdo_oe_out,        // Serial out enable
    input  wire [NUM_IN-1:0] in_pin_in,         // Functional input pins
    input  wire [NUM_IO-1:0] io_pin_in,         // Bidirectional pin level
    input  wire [NUM_IO-1:0] core_io_in,        // Core value for io pins
    input  wire [NUM_IO-1:0] core_oe_in,        // Core enable for io pins
    output reg  [NUM_IO-1:0] io_pin_out,        // Value to io pins
    output reg  [NUM_IO-1:0] io_pin_oe_out,     // Enable to io pins
    output reg               test_mode_out,     // Test logic owns pins
    output reg               idle_active_out,   // Test logic runs in idle
    output reg  [3:0]        instr_out          // Current instruction
);

    // Inputs take the low chain bits, io pins sit above them
    localparam BS_LEN = NUM_IN + NUM_IO;

    localparam [3:0] ST_RESET    = 4'h0;
    localparam [3:0] ST_IDLE     = 4'h1;
    localparam [3:0] ST_SEL_DR   = 4'h2;
    localparam [3:0] ST_CAP_DR   = 4'h3;
    localparam [3:0] ST_SH_DR    = 4'h4;
    localparam [3:0] ST_EX1_DR   = 4'h5;
    localparam [3:0] ST_PAU_DR   = 4'h6;
    localparam [3:0] ST_EX2_DR   = 4'h7;
    localparam [3:0] ST_UPD_DR   = 4'h8;
    localparam [3:0] ST_SEL_IR   = 4'h9;
    localparam [3:0] ST_CAP_IR   = 4'hA;
    localparam [3:0] ST_SH_IR    = 4'hB;
    localparam [3:0] ST_EX1_IR   = 4'hC;
    localparam [3:0] ST_PAU_IR   = 4'hD;
    localparam [3:0] ST_EX2_IR   = 4'hE;
    localparam [3:0] ST_UPD_IR   = 4'hF;

    // Next state of the test-port controller
    function [3:0] step_state;
        input [3:0] st;
        input       tms;
        begin
            case (st)
                ST_RESET:  step_state = tms ? ST_RESET  : ST_IDLE;
                ST_IDLE:   step_state = tms ? ST_SEL_DR : ST_IDLE;
                ST_SEL_DR: step_state = tms ? ST_SEL_IR : ST_CAP_DR;
                ST_CAP_DR: step_state = tms ? ST_EX1_DR : ST_SH_DR;
                ST_SH_DR:  step_state = tms ? ST_EX1_DR : ST_SH_DR;
                ST_EX1_DR: step_state = tms ? ST_UPD_DR : ST_PAU_DR;
                ST_PAU_DR: step_state = tms ? ST_EX2_DR : ST_PAU_DR;
                ST_EX2_DR: step_state = tms ? ST_UPD_DR : ST_SH_DR;
                ST_UPD_DR: step_state = tms ? ST_SEL_DR : ST_IDLE;
                ST_SEL_IR: step_state = tms ? ST_RESET  : ST_CAP_IR;
                ST_CAP_IR: step_state = tms ? ST_EX1_IR : ST_SH_IR;
                ST_SH_IR:  step_state = tms ? ST_EX1_IR : ST_SH_IR;
                ST_EX1_IR: step_state = tms ? ST_UPD_IR : ST_PAU_IR;
                ST_PAU_IR: step_state = tms ? ST_EX2_IR : ST_PAU_IR;
                ST_EX2_IR: step_state = tms ? ST_UPD_IR : ST_SH_IR;
                ST_UPD_IR: step_state = tms ? ST_SEL_DR : ST_IDLE;
                default:   step_state = ST_RESET;
            endcase
        end
    endfunction

    // Data register chosen by an instruction
    // Reserved codes fall back to the bypass stage
    function [1:0] dr_select;
        input [3:0] op;
        begin
            case (op)
                `BST_OP_EXTEST: dr_select = `BST_SEL_CHAIN;
                `BST_OP_SAMPLE: dr_select = `BST_SEL_CHAIN;
                `BST_OP_IDCODE: dr_select = `BST_SEL_IDENT;
                `BST_OP_HIGHZ:  dr_select = `BST_SEL_BYPASS;
                `BST_OP_CLAMP:  dr_select = `BST_SEL_BYPASS;
                default:        dr_select = `BST_SEL_BYPASS;
            endcase
        end
    endfunction

    // Pins take their values from the chain under these instructions
    function owns_pins;
        input [3:0] op;
        begin
            owns_pins = (op == `BST_OP_EXTEST) ||
                        (op == `BST_OP_CLAMP)  ||
                        (op == `BST_OP_HIGHZ);
        end
    endfunction

    // Input synchronisers; reset levels match the idle pins,
    // so no false test-clock edge follows reset
    reg              tck_m;
    reg              tck_s;
    reg              tck_d;
    reg              tms_m;
    reg              tms_s;
    reg              tdi_m;
    reg              tdi_s;
    reg [NUM_IN-1:0] in_m;
    reg [NUM_IN-1:0] in_s;
    reg [NUM_IO-1:0] io_m;
    reg [NUM_IO-1:0] io_s;

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            tck_m <= 1'b0;
            tck_s <= 1'b0;
            tck_d <= 1'b0;
            tms_m <= 1'b1;
            tms_s <= 1'b1;
            tdi_m <= 1'b1;
            tdi_s <= 1'b1;
            in_m  <= {NUM_IN{1'b0}};
            in_s  <= {NUM_IN{1'b0}};
            io_m  <= {NUM_IO{1'b0}};
            io_s  <= {NUM_IO{1'b0}};
        end else begin
            tck_m <= tck_in;
            tck_s <= tck_m;
            tck_d <= tck_s;
            tms_m <= tms_in;
            tms_s <= tms_m;
            tdi_m <= tdi_in;
            tdi_s <= tdi_m;
            in_m  <= in_pin_in;
            in_s  <= in_m;
            io_m  <= io_pin_in;
            io_s  <= io_m;
        end
    end

    wire tck_rise = tck_s & ~tck_d;
    wire tck_fall = ~tck_s & tck_d;

    // Serial output buffer, two entries
    // Drains only while the test clock is low
    reg [1:0] buf_data;
    reg       buf_wr;
    reg       buf_rd;
    reg [1:0] buf_count;
    wire      buf_full  = (buf_count == `BST_BUF_DEPTH);
    wire      buf_in_rdy = ~buf_full;
    wire      buf_out_vld = (buf_count != 2'h0);
    wire      buf_out_rdy = ~tck_s;

    // A rising edge is acted on only while the buffer has room
    // (never refused while rises and falls alternate)
    wire      advance = tck_rise & buf_in_rdy;

    reg [3:0]        state;
    reg [3:0]        ir_shift;
    reg [3:0]        instruction_hold;
    reg              bypass_stage;
    reg [BS_LEN-1:0] boundary_chain;
    reg [BS_LEN-1:0] chain_update;
    reg [31:0]       id_shift;

    wire [1:0] sel = dr_select(instruction_hold);
    wire       shifting = (state == ST_SH_IR) || (state == ST_SH_DR);
    // Pin test reads back the levels that the chain drives
    wire       pin_test = (instruction_hold == `BST_OP_EXTEST);

    wire [31:0] identification_word;
    assign identification_word[`BST_ID_REV_MSB:`BST_ID_REV_LSB]   =
        ID_REVISION;
    assign identification_word[`BST_ID_PART_MSB:`BST_ID_PART_LSB] =
        ID_PART;
    assign identification_word[`BST_ID_MFR_MSB:`BST_ID_MFR_LSB]   =
        ID_MAKER;
    assign identification_word[`BST_ID_MARK_BIT] = `BST_ID_MARK;

    // Boundary cell capture values
    wire [BS_LEN-1:0] chain_capture;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_IN; gi = gi + 1) begin : g_in_cell
            assign chain_capture[gi] = in_s[gi];
        end
        for (gi = 0; gi < NUM_IO; gi = gi + 1) begin : g_io_cell
            // Shared cell: core value when the core drives, else pin
            // level; pin test always reads the pin back
            assign chain_capture[NUM_IN + gi] =
                (core_oe_in[gi] && !pin_test) ? core_io_in[gi]
                                              : io_s[gi];
        end
    endgenerate

    // Bit leaving the selected path toward the serial output
    reg serial_bit;
    always @* begin
        serial_bit = bypass_stage;
        if (state == ST_SH_IR) begin
            serial_bit = ir_shift[0];
        end else begin
            case (sel)
                `BST_SEL_CHAIN: serial_bit = boundary_chain[0];
                `BST_SEL_IDENT: serial_bit = id_shift[0];
                default:        serial_bit = bypass_stage;
            endcase
        end
    end

    // Controller and rising-edge register actions
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state          <= ST_RESET;
            ir_shift       <= `BST_IR_CAPTURE;
            bypass_stage   <= 1'b0;
            boundary_chain <= {BS_LEN{1'b0}};
            id_shift       <= {`BST_ID_W{1'b0}};
        end else if (advance) begin
            state <= step_state(state, tms_s);
            case (state)
                ST_CAP_IR: ir_shift <= `BST_IR_CAPTURE;
                ST_SH_IR:  ir_shift <= {tdi_s, ir_shift[3:1]};
                ST_CAP_DR: begin
                    case (sel)
                        `BST_SEL_CHAIN:
                            boundary_chain <= chain_capture;
                        `BST_SEL_IDENT:
                            id_shift <= identification_word;
                        default:
                            bypass_stage <= 1'b0;
                    endcase
                end
                ST_SH_DR: begin
                    case (sel)
                        `BST_SEL_CHAIN:
                            boundary_chain <= {tdi_s,
                                boundary_chain[BS_LEN-1:1]};
                        `BST_SEL_IDENT:
                            id_shift <= {tdi_s, id_shift[31:1]};
                        default:
                            bypass_stage <= tdi_s;
                    endcase
                end
                default: begin
                    // Pause and exit states hold the shift stages
                    ir_shift <= ir_shift;
                end
            endcase
        end
    end

    // Falling-edge updates
    // Reset state reloads the identify instruction each cycle
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            instruction_hold <= `BST_OP_RESET;
            chain_update     <= {BS_LEN{1'b0}};
        end else if (state == ST_RESET) begin
            instruction_hold <= `BST_OP_RESET;
        end else if (tck_fall) begin
            if (state == ST_UPD_IR) begin
                instruction_hold <= ir_shift;
            end
            if (state == ST_UPD_DR && sel == `BST_SEL_CHAIN) begin
                chain_update <= boundary_chain;
            end
        end
    end

    // Serial output buffer fill and drain
    wire push = tck_fall & shifting & buf_in_rdy;
    wire pop  = buf_out_vld & buf_out_rdy;

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            buf_data   <= 2'h0;
            buf_wr     <= 1'b0;
            buf_rd     <= 1'b0;
            buf_count  <= 2'h0;
            tdo_out    <= 1'b0;
            tdo_oe_out <= 1'b0;
        end else begin
            if (push) begin
                buf_data[buf_wr] <= serial_bit;
                buf_wr <= ~buf_wr;
            end
            if (pop) begin
                tdo_out <= buf_data[buf_rd];
                buf_rd  <= ~buf_rd;
            end
            case ({push, pop})
                2'b10:   buf_count <= buf_count + 2'h1;
                2'b01:   buf_count <= buf_count - 2'h1;
                default: buf_count <= buf_count;
            endcase
            // Enable stays up after the rise into Exit1 until the fall in Exit1
            if (tck_fall) begin
                tdo_oe_out <= shifting;
            end
        end
    end

    // Pin control and status outputs
    // High impedance keeps the update value but drops enables
    integer k;
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            io_pin_out      <= {NUM_IO{1'b0}};
            io_pin_oe_out   <= {NUM_IO{1'b0}};
            test_mode_out   <= 1'b0;
            idle_active_out <= 1'b0;
            instr_out       <= `BST_OP_RESET;
        end else begin
            instr_out <= instruction_hold;
            test_mode_out <= (state != ST_RESET) &&
                             owns_pins(instruction_hold);
            idle_active_out <= (state == ST_IDLE) &&
                               owns_pins(instruction_hold);
            for (k = 0; k < NUM_IO; k = k + 1) begin
                if (state == ST_RESET ||
                    !owns_pins(instruction_hold)) begin
                    io_pin_out[k]    <= core_io_in[k];
                    io_pin_oe_out[k] <= core_oe_in[k];
                end else if (instruction_hold == `BST_OP_HIGHZ) begin
                    io_pin_out[k]    <= chain_update[NUM_IN + k];
                    io_pin_oe_out[k] <= 1'b0;
                end else begin
                    io_pin_out[k]    <= chain_update[NUM_IN + k];
                    io_pin_oe_out[k] <= 1'b1;
                end
            end
        end
    end

endmodule // bst_tap

/* testbench/bst_tap_asserts.sv */
// Purpose: concurrent checks on the scan port, io pin and status outputs of bst_tap
// Assumes: test clock far slower than clk_in, pins sampled through 2 FF
// Notes:   bound to every bst_tap instance
`timescale 1ns/100ps
`include "bst_regs.vh"
module bst_tap_asserts #(
    parameter NUM_IO = 4                          // Bidirectional pins
) (
    input wire logic              clk_in,         // System clock
    input wire logic              rst_in,         // Async reset
    input wire logic              tck_in,         // Test clock
    input wire logic              tms_in,         // Mode select
    input wire logic              tdo_out,        // Serial out
    input wire logic              tdo_oe_out,     // Serial out enable
    input wire logic [NUM_IO-1:0] core_io_in,     // Core io value
    input wire logic [NUM_IO-1:0] core_oe_in,     // Core io enable
    input wire logic [NUM_IO-1:0] io_pin_out,     // Pin value
    input wire logic [NUM_IO-1:0] io_pin_oe_out,  // Pin enable
    input wire logic              test_mode_out,  // Test owns pins
    input wire logic              idle_active_out, // Test runs in idle
    input wire logic [3:0]        instr_out       // Current instruction
);
    logic [2:0] tck_s;
    logic [1:0] tms_s;
    logic [2:0] ones;
    logic [1:0] stab;
    logic [3:0] prev_instr;
    // Counts mode-select highs at seen test clock rises
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            tck_s <= 3'h0;
            tms_s <= 2'h0;
            ones <= 3'h0;
            stab <= 2'h0;
            prev_instr <= 4'h0;
        end else begin
            tck_s <= {tck_s[1:0], tck_in};
            tms_s <= {tms_s[0], tms_in};
            prev_instr <= instr_out;
            if (instr_out != prev_instr)
                stab <= 2'h0;
            else if (stab != 2'h3)
                stab <= stab + 2'h1;
            if (tck_s[1] && !tck_s[2])
                ones <= !tms_s[1] ? 3'h0 :
                        (ones == 3'h7 ? ones : ones + 3'h1);
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    sequence s_ident_normal;
        instr_out == `BST_OP_IDCODE && !test_mode_out;
    endsequence
    sequence s_settled;
        stab == 2'h3 && test_mode_out && $past(test_mode_out)
            && $past(test_mode_out, 2);
    endsequence
    a_tdo_on_fall: assert property ($changed(tdo_out) |-> !tck_in)
        else $error("serial out moved while test clock high");
    a_oe_on_fall: assert property ($changed(tdo_oe_out) |-> !tck_in)
        else $error("serial enable moved while test clock high");
    a_oe_stands: assert property ($rose(tdo_oe_out) |-> tdo_oe_out[*8])
        else $error("serial enable did not stand");
    a_instr_fall: assert property (($changed(instr_out)
        && instr_out != `BST_OP_RESET) |-> !tck_in)
        else $error("instruction changed while test clock high");
    a_five_ones: assert property (
        ones == 3'h5 |-> ##[0:8] s_ident_normal)
        else $error("five mode highs did not reset");
    a_idle_test: assert property (idle_active_out |-> test_mode_out)
        else $error("idle activity without test instruction");
    a_test_ops: assert property (s_settled |-> instr_out == 4'h0
        || instr_out == `BST_OP_HIGHZ || instr_out == `BST_OP_CLAMP)
        else $error("test mode under a normal instruction");
    a_highz_oe: assert property (s_settled ##0
        instr_out == `BST_OP_HIGHZ |-> io_pin_oe_out == '0)
        else $error("pins enabled under high impedance");
    a_pin_drive: assert property (s_settled ##0
        instr_out != `BST_OP_HIGHZ |-> io_pin_oe_out == '1)
        else $error("pins not driven under pin test");
    a_normal_pins: assert property ((stab == 2'h3 && !test_mode_out
        && !$past(test_mode_out) && !$past(test_mode_out, 2))
        |-> io_pin_out == $past(core_io_in)
        && io_pin_oe_out == $past(core_oe_in))
        else $error("pins do not follow core");
endmodule // bst_tap_asserts
bind bst_tap bst_tap_asserts #(.NUM_IO(NUM_IO)) chk_u (
    .clk_in(clk_in), .rst_in(rst_in), .tck_in(tck_in), .tms_in(tms_in),
    .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out), .core_io_in(core_io_in),
    .core_oe_in(core_oe_in), .io_pin_out(io_pin_out),
    .io_pin_oe_out(io_pin_oe_out), .test_mode_out(test_mode_out),
    .idle_active_out(idle_active_out), .instr_out(instr_out));

/* testbench/bst_ctl_model.sv */
// Purpose: external test controller driving the scan port
// Assumes: test clock 32 clk_in periods, held low between frames
// Notes:   serial out sampled at test clock rise, z when not enabled
`timescale 1ns/100ps
module bst_ctl_model (
    input  wire logic clk_in,     // System clock
    output logic      tck_out,    // Test clock
    output logic      tms_out,    // Mode select
    output logic      tdi_out,    // Serial data
    input  wire logic tdo_in,     // Device serial out
    input  wire logic tdo_oe_in   // Its enable
);
    initial begin
        tck_out = 1'h0;
        tms_out = 1'h1;
        tdi_out = 1'h0;
    end
    task automatic step(input logic m, input logic d, output logic q);
        @(posedge clk_in);
        tms_out <= m;
        tdi_out <= d;
        repeat (15) @(posedge clk_in);
        tck_out <= 1'h1;
        q = tdo_oe_in ? tdo_in : 1'hz;
        repeat (16) @(posedge clk_in);
        tck_out <= 1'h0;
    endtask
    // From idle through one scan and back to idle; data LSB first
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic q;
        dout = 32'h0;
        step(1'h1, ~tdi_out, q);
        if (ir)
            step(1'h1, ~tdi_out, q);
        step(1'h0, ~tdi_out, q);
        step(1'h0, ~tdi_out, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'h1, ~tdi_out, q);
        step(1'h0, ~tdi_out, q);
    endtask
    task automatic reset5();
        logic q;
        repeat (5) step(1'h1, ~tdi_out, q);
    endtask
endmodule // bst_ctl_model

/* testbench/test_bst_tap.sv */
// Purpose: self-checking bench for bst_tap through its scan port
// Assumes: default widths of four input and four io pins
// Notes:   instruction rows in a table, reset and pause by hand
`timescale 1ns/100ps
`include "bst_regs.vh"
module test_bst_tap;
    localparam [3:0]  ID_REV = 4'h3;      // Arbitrary value
    localparam [15:0] ID_PRT = 16'hC0DE;  // Arbitrary value
    localparam [10:0] ID_MFR = 11'h155;   // Arbitrary value
    localparam [31:0] PAT = 32'h5A5A5A5A;
    localparam [31:0] BYP = {PAT[30:0], 1'h0};
    localparam [31:0] IDW = {ID_REV, ID_PRT, ID_MFR, `BST_ID_MARK};
    localparam [13:0] PZ = 14'h1923;      // Mode bits of a paused scan
    localparam [13:0] PD = 14'h3E3F;      // Data bits, zero while paused
    typedef struct packed {
        logic [3:0]  op;
        logic        tm;
        logic        ia;
        logic [3:0]  oe;
        logic [3:0]  po;
        logic        drc;
        logic [31:0] dr;
    } bst_row_t;
    // Chain capture: inputs 9, io from core where enabled else pin
    // level; pin test reads every io pin back (C)
    bst_row_t rows [7] = '{
        '{`BST_OP_SAMPLE, 1'h0, 1'h0, 4'h3, 4'h1, 1'h1, {PAT[23:0], 8'hD9}},
        '{`BST_OP_EXTEST, 1'h1, 1'h1, 4'hF, 4'h5, 1'h1, {PAT[23:0], 8'hC9}},
        '{`BST_OP_CLAMP, 1'h1, 1'h1, 4'hF, 4'h5, 1'h1, BYP},
        '{`BST_OP_HIGHZ, 1'h1, 1'h1, 4'h0, 4'h5, 1'h1, BYP},
        '{`BST_OP_IDCODE, 1'h0, 1'h0, 4'h3, 4'h1, 1'h1, IDW},
        '{`BST_OP_BYPASS, 1'h0, 1'h0, 4'h3, 4'h1, 1'h1, BYP},
        '{`BST_OP_SAMPLE, 1'h0, 1'h0, 4'h3, 4'h1, 1'h1, {PAT[23:0], 8'hD9}}};
    logic       clk_in, rst_in, tck, tms, tdi, tdo, tdo_oe, tm, ia;
    logic [3:0] io_out, io_oe, instr;
    int         num_errors = 0;
    int         checks_done = 0;
    bst_tap #(.ID_REVISION(ID_REV), .ID_PART(ID_PRT),
              .ID_MAKER(ID_MFR)) dut_u (
        .clk_in(clk_in), .rst_in(rst_in), .tck_in(tck), .tms_in(tms),
        .tdi_in(tdi), .tdo_out(tdo), .tdo_oe_out(tdo_oe),
        .in_pin_in(4'h9), .io_pin_in(4'hC), .core_io_in(4'h1),
        .core_oe_in(4'h3), .io_pin_out(io_out), .io_pin_oe_out(io_oe),
        .test_mode_out(tm), .idle_active_out(ia), .instr_out(instr));
    bst_ctl_model ctl_u (.clk_in(clk_in), .tck_out(tck), .tms_out(tms),
        .tdi_out(tdi), .tdo_in(tdo), .tdo_oe_in(tdo_oe));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task end_of_test();
        $display("checks=%0d errors=%0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        clk_in = 1'h0;
        forever #2.5 clk_in = ~clk_in;
    end
    initial begin
        repeat (90000) @(posedge clk_in);
        num_errors++;
        end_of_test();
    end
    initial begin
        logic [31:0] d;
        logic        q;
        rst_in = 1'h1;
        repeat (10) @(posedge clk_in);
        rst_in <= 1'h0;
        repeat (4) @(posedge clk_in);
        ctl_u.step(1'h0, 1'h1, q);
        ctl_u.scan(1'h0, 32, PAT, d);
        chk(d, IDW);
        chk(instr, `BST_OP_IDCODE);
        for (int i = 0; i < 7; i++) begin
            ctl_u.scan(1'h1, 4, {28'h0, rows[i].op}, d);
            chk(d, `BST_IR_CAPTURE);
            repeat (6) @(posedge clk_in);
            chk(instr, rows[i].op);
            chk(tm, rows[i].tm);
            chk(ia, rows[i].ia);
            chk(io_oe, rows[i].oe);
            if (rows[i].oe != 4'h0)
                chk(io_out, rows[i].po);
            ctl_u.scan(1'h0, 32, PAT, d);
            if (rows[i].drc)
                chk(d, rows[i].dr);
        end
        ctl_u.scan(1'h1, 4, {28'h0, `BST_OP_EXTEST}, d);
        ctl_u.reset5();
        repeat (6) @(posedge clk_in);
        chk(instr, `BST_OP_IDCODE);
        chk(tm, 1'h0);
        chk(io_out, 4'h1);
        ctl_u.step(1'h0, 1'h1, q);
        for (int i = 0; i < 14; i++)
            ctl_u.step(PZ[i], PD[i], q);
        repeat (6) @(posedge clk_in);
        chk(instr, `BST_OP_BYPASS);
        ctl_u.scan(1'h1, 4, {28'h0, `BST_OP_EXTEST}, d);
        rst_in <= 1'h1;
        repeat (3) @(posedge clk_in);
        rst_in <= 1'h0;
        repeat (3) @(posedge clk_in);
        chk(instr, `BST_OP_IDCODE);
        chk(tm, 1'h0);
        end_of_test();
    end
endmodule // test_bst_tap
